// [fdc_host_xfer.sv]
// How it works
// - fifo off at reset, configure enables
// - push-pull outputs at reset, mode picks open-drain
// - mode 11 desktop default, 01 alternate
// - desktop: dor dma bit gates irq/drq
// - alternate: always drive, tc/density active low
// - first byte is opcode, sets parameter count
// - execution starts right after last command byte
// - command-in-progress from first byte to last result
// - dma mode: specify bit zero and, in desktop mode, dor d3
// - fifo off: request per byte, ack edge clears
// - interrupt after last execution byte
// - ack selects fifo, address ignored
// - terminal count ends transfer, only with ack
// - desktop fifo off: one byte per request
// - alternate fifo off: threshold 0fh, ack rearms
// - read trigger at 16 minus threshold bytes
// - burst drops request at each ack edge, raises it again at trigger
// - non-burst drops, rearms after 350 ns
// - empty drops request; sector end forces request
// - non-dma: interrupt per execution byte with fifo off, at trigger with fifo on
// - threshold comes from configure parameter
// - burst-disable bit selects non-burst mode
module fdc_host_xfer
    import fdc_xfer_pkg::*;
(
    // clock and reset
    input  wire logic       SYS_CLK,
    input  wire logic       RESET,
    // host register access, synchronous strobes
    input  wire logic       CS_N,
    input  wire logic       RD_N,
    input  wire logic       WR_N,
    input  wire logic       DATA_SEL,
    input  wire logic [7:0] HOST_WDATA,
    output logic      [7:0] HOST_RDATA,
    output logic      [7:0] MAIN_STATUS_REGISTER,
    // configuration levels
    input  wire logic [1:0] ADVANCED_SETUP_REGISTER,
    input  wire logic [7:0] DRIVE_OUTPUT_REGISTER,
    // dma pins from the system
    input  wire logic       DMA_ACKNOWLEDGE_N,
    input  wire logic       TERMINAL_COUNT,
    output logic            DMA_REQUEST,
    output logic            DMA_REQUEST_OE,
    output logic            FLOPPY_INTERRUPT,
    output logic            FLOPPY_INTERRUPT_OE,
    // disk side data path
    input  wire logic       DISK_BYTE_VALID,
    input  wire logic [7:0] DISK_BYTE,
    input  wire logic       SECTOR_END,
    input  wire logic       DENSITY_IN,
    output logic            DENSITY_SELECT_OUT,
    output logic            OPEN_DRAIN_MODE
);
    import fdc_xfer_pkg::*;

    // the block counts command bytes into phases, moves disk
    // bytes through a small fifo to the host, and decides when
    // the dma request and interrupt pins are raised.
    // everything runs on the one system clock; only the dma
    // pins come from outside it; they and the unused read strobe are synchronised first.

    // pin synchronisers: first stage feeds only the second
    logic [2:0] sync1_q;
    logic [2:0] sync2_q;
    logic       ack_prev_q;
    always_ff @(posedge SYS_CLK or posedge RESET) begin
        if (RESET) begin
            sync1_q    <= 3'h7;
            sync2_q    <= 3'h7;
            ack_prev_q <= 1'b1;
        end else begin
            sync1_q    <= {DMA_ACKNOWLEDGE_N, TERMINAL_COUNT, RD_N};
            sync2_q    <= sync1_q;
            ack_prev_q <= sync2_q[2];
        end
    end
    wire ack_n    = sync2_q[2];
    wire tc_raw   = sync2_q[1];
    wire rd_n_s   = sync2_q[0];
    wire ack_fall = ack_prev_q && !ack_n;
    wire ack_rise = !ack_prev_q && ack_n;
    // stages reset to the idle high level of the acknowledge,
    // so no false falling edge follows reset; an edge is seen
    // two clocks after the pin moves

    // only the alternate code changes behaviour; every other
    // code, reserved ones included, falls back to desktop
    // mode decode
    wire alt_system_mode     = (ADVANCED_SETUP_REGISTER == MODE_ALT);
    wire desktop_compat_mode = !alt_system_mode;
    wire tc_level  = alt_system_mode ? !tc_raw : tc_raw;
    wire tc_hit    = tc_level && !ack_n;

    // state written by the sequencer and the command bytes;
    // the host sees it only through the pins and status
    // configuration held by the block
    phase_type  phase_q;
    logic       fifo_en_q;       // configure fifo enable
    logic [3:0] trig_q;          // fifo_trigger_level
    logic       burst_dis_q;     // burst_disable
    logic       nodma_q;         // specify non-dma bit
    logic       open_drain_q;    // mode output type
    logic [4:0] opcode_q;        // latched opcode
    logic [3:0] left_q;          // bytes remaining in phase
    logic [3:0] pidx_q;          // parameter index
    logic       irq_q;           // interrupt latch
    logic       drq_q;           // request latch
    logic [4:0] rearm_q;         // non-burst rearm delay
    logic       sec_end_q;       // sector finished on disk
    logic       tc_seen_q;       // transfer terminated

    // one fifo serves all modes; with the fifo off in desktop
    // mode it still stores every disk byte, but requests one at a time
    // data path fifo
    fifo_if ff ();
    byte_fifo #(.DEPTH(FIFO_DEPTH)) u_fifo (
        .SYS_CLK (SYS_CLK),
        .RESET   (RESET),
        .f       (ff)
    );

    // alternate mode runs the fifo even when nominally off,
    // with the top threshold, so one byte is enough to request;
    // the read trigger level is depth minus threshold, 1 to 16
    // effective fifo behaviour
    wire       dma_mode  = !nodma_q && (alt_system_mode || DRIVE_OUTPUT_REGISTER[DOR_DMA_EN]);
    wire       use_fifo  = fifo_en_q || alt_system_mode;
    wire [3:0] trig_eff  = fifo_en_q ? trig_q : TRIG_ALT;
    wire [4:0] need      = 5'(FIFO_DEPTH) - {1'b0, trig_eff};
    wire       nonburst  = fifo_en_q && burst_dis_q;
    wire       in_exec   = (phase_q == PH_EXEC);
    wire       fifo_has  = (ff.count != 5'h00);

    // a dma cycle never uses chip select; the acknowledge edge
    // alone pops a byte, with or without a read strobe
    // host access decode; ack acts as fifo select
    wire host_wr   = !CS_N && !WR_N && DATA_SEL;
    wire host_rd   = !CS_N && !RD_N && DATA_SEL;
    wire dma_take  = in_exec && ack_fall;
    wire pio_take  = in_exec && host_rd && !dma_mode;
    wire take      = (dma_take && dma_mode) || pio_take;
    wire cmd_byte  = host_wr && (phase_q == PH_IDLE || phase_q == PH_CMD);
    wire res_byte  = host_rd && (phase_q == PH_RES);

    // unknown opcodes count as single-byte commands and leave
    // the block idle, so a stray write cannot lock it up
    // command parameter count from the opcode
    wire [4:0] op_in = HOST_WDATA[4:0];
    wire [3:0] nparam =
        (op_in == OP_READ || op_in == OP_WRITE) ? NPARAM_RW :
        (op_in == OP_SPECIFY)   ? NPARAM_SPEC :
        (op_in == OP_CONFIGURE) ? NPARAM_CONF :
        (op_in == OP_MODE)      ? NPARAM_MODE : NPARAM_NONE;
    wire last_cmd   = (phase_q == PH_CMD && left_q == 4'h1) ||
                      (phase_q == PH_IDLE && nparam == NPARAM_NONE);
    wire has_exec   = (opcode_q == OP_READ) || (opcode_q == OP_WRITE);

    // disk bytes stop entering once terminal count has ended
    // the transfer; the fifo is emptied whenever idle
    // fifo controls
    assign ff.wdata = DISK_BYTE;
    assign ff.push  = in_exec && DISK_BYTE_VALID && !tc_seen_q;
    assign ff.pop   = take;
    assign ff.flush = (phase_q == PH_IDLE);

    // a transfer cut by terminal count ends at once; otherwise
    // the host must have taken every byte of the sector first
    // execution finished on tc, or when disk data ended and fifo drained
    wire exec_done = in_exec && (tc_seen_q || tc_hit || (sec_end_q && !fifo_has)) &&
                     !(fifo_has && !tc_seen_q && !tc_hit);

    // idle takes the opcode, command counts parameters down,
    // execution waits for the data to end, and result counts
    // the result bytes down before going back to idle
    // phase sequencer
    always_ff @(posedge SYS_CLK or posedge RESET) begin
        if (RESET) begin
            phase_q <= PH_IDLE;
            opcode_q <= 5'h00;
            left_q   <= 4'h0;
            pidx_q   <= 4'h0;
        end else begin
            unique case (phase_q)
                PH_IDLE: if (cmd_byte) begin
                    opcode_q <= op_in;
                    left_q   <= nparam;
                    pidx_q   <= 4'h0;
                    phase_q  <= (nparam == NPARAM_NONE) ? PH_IDLE : PH_CMD;
                end
                PH_CMD: if (cmd_byte) begin
                    left_q <= left_q - 4'h1;
                    pidx_q <= pidx_q + 4'h1;
                    if (last_cmd) begin
                        phase_q <= has_exec ? PH_EXEC : PH_IDLE;
                        left_q  <= NRESULT_RW;
                    end
                end
                PH_EXEC: if (exec_done) phase_q <= PH_RES;
                PH_RES: if (res_byte) begin
                    left_q <= left_q - 4'h1;
                    if (left_q == 4'h1) phase_q <= PH_IDLE;
                end
                default: phase_q <= PH_IDLE;
            endcase
        end
    end

    // only the second parameter byte carries fields kept here;
    // the other parameter bytes pass through unused
    // parameters picked from command bytes
    wire p_write = cmd_byte && (phase_q == PH_CMD);
    always_ff @(posedge SYS_CLK or posedge RESET) begin
        if (RESET) begin
            fifo_en_q    <= 1'b0;
            trig_q       <= TRIG_RESET;
            burst_dis_q  <= 1'b0;
            nodma_q      <= 1'b0;
            open_drain_q <= 1'b0;
        end else if (p_write) begin
            if (opcode_q == OP_CONFIGURE && pidx_q == 4'h1) begin
                fifo_en_q <= !HOST_WDATA[5];
                trig_q    <= HOST_WDATA[3:0];
            end
            if (opcode_q == OP_SPECIFY && pidx_q == 4'h1)
                nodma_q <= HOST_WDATA[0];
            if (opcode_q == OP_MODE && pidx_q == 4'h1) begin
                burst_dis_q  <= HOST_WDATA[1];
                open_drain_q <= HOST_WDATA[0];
            end
        end
    end

    // both latches live for one execution phase only and
    // clear as soon as the phase is left
    // sector end and terminal count latches
    always_ff @(posedge SYS_CLK or posedge RESET) begin
        if (RESET) begin
            sec_end_q <= 1'b0;
            tc_seen_q <= 1'b0;
        end else if (!in_exec) begin
            sec_end_q <= 1'b0;
            tc_seen_q <= 1'b0;
        end else begin
            if (SECTOR_END) sec_end_q <= 1'b1;
            if (tc_hit) tc_seen_q <= 1'b1;
        end
    end

    // with the fifo on in burst mode, a request waits for the trigger level
    // or for a finished sector with bytes still left behind
    // request trigger conditions
    wire trig_ok   = use_fifo ? ((ff.count >= need) || (sec_end_q && fifo_has))
                              : fifo_has;
    wire desk_single = !use_fifo;
    wire alt_single  = alt_system_mode && !fifo_en_q;
    // true while the non-burst gap is still counting down
    wire rearm_busy  = (rearm_q != 5'h00);

    // priority: terminal count and phase end, then the ack
    // edge, then an empty fifo; only then may the request rise,
    // by the rule of the mode in force. the rearm counter keeps
    // a non-burst request down for the settling gap
    // dma request latch: set on trigger, cleared by ack edge, empty or delay
    always_ff @(posedge SYS_CLK or posedge RESET) begin
        if (RESET) begin
            drq_q   <= 1'b0;
            rearm_q <= 5'h00;
        end else begin
            if (rearm_busy) rearm_q <= rearm_q - 5'h01;
            if (!in_exec || !dma_mode || tc_hit || tc_seen_q) begin
                drq_q <= 1'b0;
            end else if (ack_fall) begin
                drq_q <= 1'b0;
                if (nonburst) rearm_q <= REARM_LOAD;
            end else if (drq_q && !fifo_has) begin
                drq_q <= 1'b0;
            end else if (!drq_q && !ack_n) begin
                drq_q <= 1'b0;
            end else if (!drq_q && (desk_single || alt_single)) begin
                if (ack_n && fifo_has) drq_q <= 1'b1;
            end else if (!drq_q && nonburst) begin
                if (!rearm_busy && fifo_has && (trig_ok || ack_prev_q)) drq_q <= 1'b1;
            end else if (!drq_q && trig_ok) begin
                drq_q <= 1'b1;
            end
        end
    end

    // the end-of-execution interrupt outranks the per-byte one
    // and stays until the host reads the first result byte
    // interrupt latch: per-byte or at trigger in non-dma, end of execution always
    always_ff @(posedge SYS_CLK or posedge RESET) begin
        if (RESET) begin
            irq_q <= 1'b0;
        end else if (exec_done) begin
            irq_q <= 1'b1;
        end else if (res_byte) begin
            irq_q <= 1'b0;
        end else if (in_exec && !dma_mode) begin
            irq_q <= use_fifo ? (trig_ok && fifo_has) : fifo_has;
        end else if (!in_exec && phase_q != PH_RES) begin
            irq_q <= 1'b0;
        end
    end

    // request-for-master follows the interrupt in a non-dma
    // transfer, so a polling host sees the same event as the pin
    // main status register view
    wire request_for_master = (phase_q == PH_IDLE) || (phase_q == PH_CMD) ||
               (phase_q == PH_RES) || (in_exec && !dma_mode && irq_q);
    wire transfer_direction_bit = (phase_q == PH_RES) || (in_exec && !dma_mode);
    wire cip = (phase_q != PH_IDLE);
    wire [7:0] msr_d = (8'(request_for_master) << MSR_RQM) | (8'(transfer_direction_bit) << MSR_DIO) |
                       (8'(in_exec && !dma_mode) << MSR_NDMA) | (8'(cip) << MSR_CIP);

    // read data shows the fifo head one clock late, which is
    // when the host or the dma cycle samples it
    // registered outputs
    always_ff @(posedge SYS_CLK or posedge RESET) begin
        if (RESET) begin
            HOST_RDATA           <= 8'h00;
            MAIN_STATUS_REGISTER <= MSR_RESET;
        end else begin
            HOST_RDATA           <= ff.rdata;
            MAIN_STATUS_REGISTER <= msr_d;
        end
    end

    // the enables only decide whether a pin is driven; the
    // open-drain choice reaches the pads through its own port
    // pin drive: desktop mode gates by dor dma bit
    wire pin_en = alt_system_mode || DRIVE_OUTPUT_REGISTER[DOR_DMA_EN];
    assign DMA_REQUEST         = drq_q;
    assign DMA_REQUEST_OE      = pin_en;
    assign FLOPPY_INTERRUPT    = irq_q;
    assign FLOPPY_INTERRUPT_OE = pin_en;
    assign DENSITY_SELECT_OUT  = desktop_compat_mode ? DENSITY_IN : !DENSITY_IN;
    assign OPEN_DRAIN_MODE     = open_drain_q;
    // the synchronised read strobe waits for a later read path;
    // host strobes are taken as synchronous levels today
    wire unused_ok = rd_n_s;
endmodule : fdc_host_xfer

// [fdc_xfer_pkg.sv]
package fdc_xfer_pkg;
    // fifo geometry
    localparam int FIFO_DEPTH          = 16;
    localparam int FIFO_AW             = 5;
    localparam logic [3:0] TRIG_RESET  = 4'h0;
    localparam logic [3:0] TRIG_ALT    = 4'hf;
    // two-bit mode setting codes
    localparam logic [1:0] MODE_DESKTOP = 2'h3;
    localparam logic [1:0] MODE_ALT     = 2'h1;
    // main status register bit positions
    localparam int MSR_RQM  = 7;
    localparam int MSR_DIO  = 6;
    localparam int MSR_NDMA = 5;
    localparam int MSR_CIP  = 4;
    localparam logic [7:0] MSR_RESET = 8'h80;   // ready for a command, idle
    // drive output register dma-enable position
    localparam int DOR_DMA_EN = 3;
    // timing
    localparam int CLK_HZ          = 25000000;
    localparam int REARM_NS        = 350;
    localparam int REARM_CYC       = (REARM_NS * (CLK_HZ / 1000000) + 999) / 1000;
    localparam logic [4:0] REARM_LOAD = 5'(REARM_CYC);
    // opcodes recognised for parameter count
    localparam logic [4:0] OP_READ      = 5'h06;
    localparam logic [4:0] OP_WRITE     = 5'h05;
    localparam logic [4:0] OP_SPECIFY   = 5'h03;
    localparam logic [4:0] OP_CONFIGURE = 5'h13;
    localparam logic [4:0] OP_MODE      = 5'h01;
    localparam logic [3:0] NPARAM_RW    = 4'h8;
    localparam logic [3:0] NPARAM_SPEC  = 4'h2;
    localparam logic [3:0] NPARAM_CONF  = 4'h3;
    localparam logic [3:0] NPARAM_MODE  = 4'h4;
    localparam logic [3:0] NPARAM_NONE  = 4'h0;
    localparam logic [3:0] NRESULT_RW   = 4'h7;
    // phase state machine
    typedef enum logic [3:0] {
        PH_IDLE = 4'b0001,
        PH_CMD  = 4'b0010,
        PH_EXEC = 4'b0100,
        PH_RES  = 4'b1000
    } phase_type;
endpackage : fdc_xfer_pkg

// [fifo_if.sv]
interface fifo_if;
    logic [7:0] wdata;
    logic       push;
    logic       pop;
    logic       flush;
    logic [7:0] rdata;
    logic [4:0] count;
    modport owner (output wdata, push, pop, flush, input rdata, count);
    modport store (input wdata, push, pop, flush, output rdata, count);
endinterface : fifo_if

// [byte_fifo.sv]
module byte_fifo
    import fdc_xfer_pkg::*;
#(
    parameter int DEPTH = FIFO_DEPTH
) (
    // clock and reset
    input  wire logic SYS_CLK,
    input  wire logic RESET,
    // fifo access
    fifo_if.store     f
);
    logic [7:0] mem [DEPTH];    // storage array
    logic [3:0] wr_q;           // write pointer
    logic [3:0] rd_q;           // read pointer
    logic [4:0] cnt_q;          // fill count
    wire        do_push = f.push && (cnt_q < 5'(DEPTH));
    wire        do_pop  = f.pop && (cnt_q != 5'h00);

    assign f.rdata = mem[rd_q];
    assign f.count = cnt_q;

    // pointer and count update
    always_ff @(posedge SYS_CLK or posedge RESET) begin
        if (RESET) begin
            wr_q  <= 4'h0;
            rd_q  <= 4'h0;
            cnt_q <= 5'h00;
        end else if (f.flush) begin
            wr_q  <= 4'h0;
            rd_q  <= 4'h0;
            cnt_q <= 5'h00;
        end else begin
            if (do_push) wr_q <= wr_q + 4'h1;
            if (do_pop)  rd_q <= rd_q + 4'h1;
            cnt_q <= cnt_q + 5'(do_push) - 5'(do_pop);
        end
    end

    // data store
    always_ff @(posedge SYS_CLK) begin
        if (do_push) mem[wr_q] <= f.wdata;
    end
endmodule : byte_fifo

// [fdc_host_xfer_monitor.sv]
module fdc_host_xfer_monitor (
    // clock and reset
    input logic       SYS_CLK,
    input logic       RESET,
    // host access
    input logic       CS_N,
    input logic       WR_N,
    input logic       DATA_SEL,
    input logic [7:0] HOST_WDATA,
    input logic [7:0] MAIN_STATUS_REGISTER,
    // configuration
    input logic [1:0] ADVANCED_SETUP_REGISTER,
    input logic [7:0] DRIVE_OUTPUT_REGISTER,
    // dma and pins
    input logic       DMA_ACKNOWLEDGE_N,
    input logic       DMA_REQUEST,
    input logic       DMA_REQUEST_OE,
    input logic       FLOPPY_INTERRUPT_OE,
    input logic       DENSITY_IN,
    input logic       DENSITY_SELECT_OUT,
    input logic       OPEN_DRAIN_MODE
);
    timeunit 1ns;
    timeprecision 100ps;
    import fdc_xfer_pkg::*;
    // all checks live in the one clock domain
    default clocking @(posedge SYS_CLK); endclocking
    default disable iff (RESET);
    wire alt_m = ADVANCED_SETUP_REGISTER == MODE_ALT;  // alternate register set chosen
    wire cip   = MAIN_STATUS_REGISTER[MSR_CIP];        // command in progress
    chk_reset_state: assert property ($fell(RESET) |-> MAIN_STATUS_REGISTER == 8'h80
        && !DMA_REQUEST && !OPEN_DRAIN_MODE) else $error("bad state after reset");
    chk_alt_drives: assert property (alt_m [*2] |-> DMA_REQUEST_OE && FLOPPY_INTERRUPT_OE)
        else $error("outputs floated in alternate mode");
    chk_dor_gates: assert property ((!alt_m && !DRIVE_OUTPUT_REGISTER[DOR_DMA_EN]) [*2]
        |-> !DMA_REQUEST_OE && !FLOPPY_INTERRUPT_OE) else $error("outputs driven with dma bit clear");
    chk_dens_alt: assert property ((alt_m && DENSITY_IN) [*3] |-> !DENSITY_SELECT_OUT)
        else $error("density not inverted");
    chk_dens_desk: assert property ((!alt_m && DENSITY_IN) [*3] |-> DENSITY_SELECT_OUT)
        else $error("density inverted");
    chk_ack_drops_drq: assert property ($fell(DMA_ACKNOWLEDGE_N) |-> ##[1:5] !DMA_REQUEST)
        else $error("request kept after acknowledge");
    chk_drq_holds: assert property ((DMA_REQUEST && DMA_ACKNOWLEDGE_N) [*4] |=> DMA_REQUEST)
        else $error("request dropped without acknowledge");
    chk_opcode_busy: assert property ((!CS_N && !WR_N && DATA_SEL && MAIN_STATUS_REGISTER == 8'h80
        && HOST_WDATA[4:0] == OP_READ) |-> ##[1:3] cip) else $error("busy bit not set");
    chk_idle_no_drq: assert property (!cip [*2] |-> !DMA_REQUEST)
        else $error("request outside a command");
    // main scenarios reached
    cover property ($fell(DMA_REQUEST));
    cover property (alt_m && DMA_REQUEST_OE);
    cover property ($rose(cip));
endmodule : fdc_host_xfer_monitor

bind fdc_host_xfer fdc_host_xfer_monitor i_mon (.*);

// [dma_partner.sv]
module dma_partner (
    // clock
    input  logic       clk,
    // request in, acknowledge and count out
    input  logic       dma_request,
    output logic       dma_acknowledge_n,
    output logic       terminal_count,
    // control from the bench
    input  logic       enable,
    input  logic [3:0] wait_cycles,
    input  logic       tc_low,
    output int         acks
);
    timeunit 1ns;
    timeprecision 100ps;
    // count is never raised: it idles at the inactive level of the mode
    assign terminal_count = tc_low;
    // one acknowledge strobe per request, no read strobe, chip select untouched
    initial begin
        dma_acknowledge_n = 1'b1;
        acks = 0;
        forever begin
            @(posedge clk);
            if (enable && dma_request) begin
                repeat (wait_cycles) @(posedge clk);
                #1 dma_acknowledge_n = 1'b0;
                repeat (4) @(posedge clk);
                #1 dma_acknowledge_n = 1'b1;
                acks = acks + 1;
                repeat (3) @(posedge clk);
            end
        end
    end
endmodule : dma_partner

// [tb_top.sv]
module tb_top;
    timeunit 1ns;
    timeprecision 100ps;
    import fdc_xfer_pkg::*;
    logic       SYS_CLK = 0, RESET = 1, CS_N = 1, RD_N = 1, WR_N = 1, DATA_SEL = 0;
    logic [7:0] HOST_WDATA = 8'h00, DRIVE_OUTPUT_REGISTER = 8'h00, DISK_BYTE = 8'h00;
    logic [1:0] ADVANCED_SETUP_REGISTER = MODE_DESKTOP;
    logic       DISK_BYTE_VALID = 0, SECTOR_END = 0, DENSITY_IN = 0;
    logic       DMA_ACKNOWLEDGE_N, TERMINAL_COUNT, DMA_REQUEST, DMA_REQUEST_OE;
    logic       FLOPPY_INTERRUPT, FLOPPY_INTERRUPT_OE, DENSITY_SELECT_OUT, OPEN_DRAIN_MODE;
    logic [7:0] HOST_RDATA, MAIN_STATUS_REGISTER;
    logic       dma_on = 0;       // partner answers requests
    logic [3:0] dma_wait = 4'h0;  // partner answer delay
    int         acks;             // strobes given by partner
    int         failures = 0;
    int         checks_done = 0;
    // 25 MHz clock
    always #20 SYS_CLK = ~SYS_CLK;
    fdc_host_xfer i_dut (.*);
    dma_partner i_dma (.clk(SYS_CLK), .dma_request(DMA_REQUEST), .dma_acknowledge_n(DMA_ACKNOWLEDGE_N),
        .terminal_count(TERMINAL_COUNT), .enable(dma_on), .wait_cycles(dma_wait),
        .tc_low(ADVANCED_SETUP_REGISTER == MODE_ALT), .acks(acks));
    // verdict and end of run
    task test_done;
        $display("checks %0d mismatches %0d", checks_done, failures);
        if (failures == 0 && checks_done > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask : test_done
    // compare seen against expected
    task chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
        checks_done++;
        if (seen !== exp) begin
            failures++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk
    // advance n edges, land just after the last
    task tick(input int n);
        repeat (n) @(posedge SYS_CLK);
        #1;
    endtask : tick
    // bounded wait: 0 request, 1 interrupt, 2 ready for write, 3 ready for read
    task wait_sig(input int which, input logic lvl);
        logic s;
        for (int i = 0; i < 300; i++) begin
            case (which)
                0: s = DMA_REQUEST;
                1: s = FLOPPY_INTERRUPT;
                default: s = MAIN_STATUS_REGISTER[MSR_RQM] && (MAIN_STATUS_REGISTER[MSR_DIO] == (which == 3));
            endcase
            if (s === lvl) return;
            tick(1);
        end
        failures++;
        $display("mismatch wait %0d expected %b seen timeout", which, lvl);
        test_done();
    endtask : wait_sig
    // one data register write after polling status
    task hbyte(input logic [7:0] b);
        wait_sig(2, 1'b1);
        CS_N = 0; WR_N = 0; DATA_SEL = 1; HOST_WDATA = b;
        tick(1);
        CS_N = 1; WR_N = 1;
        tick(1);
    endtask : hbyte
    // opcode then n parameters, second parameter given
    task cmd(input logic [7:0] op, input int n, input logic [7:0] p2);
        hbyte(op);
        for (int i = 1; i <= n; i++) hbyte(i == 2 ? p2 : 8'h00);
    endtask : cmd
    // reset values at the pins
    task t_reset;
        chk("status", MAIN_STATUS_REGISTER, 8'h80);
        chk("request", {7'h0, DMA_REQUEST}, 8'h00);
        chk("open drain", {7'h0, OPEN_DRAIN_MODE}, 8'h00);
        chk("request oe", {7'h0, DMA_REQUEST_OE}, 8'h00);
        $display("reset test done");
    endtask : t_reset
    // both mode codes: output gating and density polarity
    task t_modes;
        logic [1:0] m [2] = '{MODE_DESKTOP, MODE_ALT};
        DENSITY_IN = 1;
        foreach (m[j]) begin
            ADVANCED_SETUP_REGISTER = m[j];
            tick(4);
            chk("request oe", {7'h0, DMA_REQUEST_OE}, {7'h0, m[j] == MODE_ALT});
            chk("interrupt oe", {7'h0, FLOPPY_INTERRUPT_OE}, {7'h0, m[j] == MODE_ALT});
            chk("density", {7'h0, DENSITY_SELECT_OUT}, {7'h0, m[j] != MODE_ALT});
        end
        ADVANCED_SETUP_REGISTER = MODE_DESKTOP;
        $display("mode test done");
    endtask : t_modes
    // mode command switches to open drain, no result phase
    task t_open_drain;
        cmd({3'h0, OP_MODE}, 4, 8'h01);
        tick(3);
        chk("open drain", {7'h0, OPEN_DRAIN_MODE}, 8'h01);
        chk("status", MAIN_STATUS_REGISTER, 8'h80);
        cmd({3'h0, OP_MODE}, 4, 8'h00);
        $display("open drain test done");
    endtask : t_open_drain
    // read, fifo off, by dma (partner answers after w cycles) or polled
    task t_xfer(input logic [3:0] w, input logic [1:0] mode, input logic pio);
        int base;
        base = acks;
        ADVANCED_SETUP_REGISTER = mode;
        DRIVE_OUTPUT_REGISTER = (mode == MODE_ALT) ? 8'h00 : 8'h08;
        dma_wait = w;
        cmd({3'h0, OP_SPECIFY}, 2, {7'h0, pio});
        cmd({3'h0, OP_READ}, 8, 8'h00);
        tick(2);
        chk("busy", {7'h0, MAIN_STATUS_REGISTER[MSR_CIP]}, 8'h01);
        dma_on = !pio;
        for (int k = 0; k < 2; k++) begin
            DISK_BYTE = 8'h5a + 8'(k);
            DISK_BYTE_VALID = 1;
            tick(1);
            DISK_BYTE_VALID = 0;
            if (pio) begin
                wait_sig(1, 1'b1);
                chk("head", HOST_RDATA, DISK_BYTE);
                wait_sig(3, 1'b1);
                CS_N = 0; RD_N = 0; DATA_SEL = 1;
                tick(1);
                CS_N = 1; RD_N = 1;
                tick(2);
                chk("byte interrupt", {7'h0, FLOPPY_INTERRUPT}, 8'h00);
            end else begin
                wait_sig(0, 1'b1);
                chk("head", HOST_RDATA, DISK_BYTE);
                wait_sig(0, 1'b0);
                tick(4);
                chk("acks", 8'(acks - base), 8'(k + 1));
            end
        end
        dma_on = 0;
        SECTOR_END = 1;
        tick(1);
        SECTOR_END = 0;
        wait_sig(1, 1'b1);
        for (int r = 0; r < 7; r++) begin
            wait_sig(3, 1'b1);
            CS_N = 0; RD_N = 0; DATA_SEL = 1;
            tick(1);
            CS_N = 1; RD_N = 1;
            tick(2);
            if (r == 0) chk("interrupt", {7'h0, FLOPPY_INTERRUPT}, 8'h00);
        end
        tick(3);
        chk("status", MAIN_STATUS_REGISTER, 8'h80);
        ADVANCED_SETUP_REGISTER = MODE_DESKTOP;
        $display("transfer test done");
    endtask : t_xfer
    // main sequence
    initial begin
        repeat (2) @(posedge SYS_CLK);
        #1 RESET = 0;
        tick(1);
        t_reset();
        t_modes();
        t_open_drain();
        t_xfer(4'h0, MODE_DESKTOP, 1'b0);
        t_xfer(4'h6, MODE_DESKTOP, 1'b0);
        t_xfer(4'h2, MODE_ALT, 1'b0);
        t_xfer(4'h0, MODE_DESKTOP, 1'b1);
        test_done();
    end
endmodule : tb_top
